// ---- core/home_search_sequencer.v ----
`timescale 1ns/1ps
`include "home_search_map.vh"
module home_search_sequencer #(
    parameter CLK_HZ = `CLK_HZ,
    parameter OFS_W = `OFS_W
) (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Command
    input wire start,
    // Configuration
    input wire sensor_sel,
    input wire home_active_high,
    input wire index_active_high,
    input wire limit_active_high,
    input wire [3:0] step_enable,
    input wire dir_step12,
    input wire dir_step3,
    input wire position_clear_en,
    input wire trapezoid_with_start_speed,
    input wire [`SPD_W-1:0] start_pps,
    input wire [`SPD_W-1:0] drive_pps,
    input wire [13:0] accel_ms,
    input wire [`SPD_W-1:0] slow_pps,
    input wire signed [OFS_W-1:0] offset,
    // Sensor pins
    input wire home_pin,
    input wire encoder_index_input,
    input wire limit_plus_pin,
    input wire limit_minus_pin,
    // Drive stage
    output reg drive_pulse,
    output reg drive_dir,
    // Status
    output reg busy,
    output reg done,
    output reg search_error,
    output reg [1:0] error_code,
    output reg soft_limit_inhibit,
    output reg position_clear
);
    localparam S_IDLE = 4'h0;
    localparam S_NEXT = 4'h1;
    localparam S_S1 = 4'h2;
    localparam S_S2_ESC = 4'h3;
    localparam S_S2_SRCH = 4'h4;
    localparam S_S3 = 4'h5;
    localparam S_S4 = 4'h6;
    localparam S_STOP = 4'h7;
    localparam S_END = 4'h8;

    reg [3:0] state;
    reg [2:0] step_no;
    reg [2:0] after_stop;
    reg [OFS_W-1:0] remain;
    reg run;
    reg ramp;
    reg halt;
    reg [`SPD_W-1:0] cur_pps;
    reg [2:0] home_s;
    reg [2:0] index_s;
    reg [2:0] lp_s;
    reg [2:0] lm_s;
    reg home_q;
    reg index_q;
    reg lp_q;
    reg lm_q;
    wire step;
    wire stopped;
    wire home_act;
    wire index_act;
    wire limit_fwd;
    wire detect;

    // Three-stage sampling; value updates once stages two and three agree
    always @(posedge mclk) begin
        if (srst) begin
            home_s <= 3'h0;
            index_s <= 3'h0;
            lp_s <= 3'h0;
            lm_s <= 3'h0;
            home_q <= 1'b0;
            index_q <= 1'b0;
            lp_q <= 1'b0;
            lm_q <= 1'b0;
        end else begin
            home_s <= {home_s[1:0], home_pin};
            index_s <= {index_s[1:0], encoder_index_input};
            lp_s <= {lp_s[1:0], limit_plus_pin};
            lm_s <= {lm_s[1:0], limit_minus_pin};
            if (home_s[1] == home_s[2])
                home_q <= home_s[2];
            if (index_s[1] == index_s[2])
                index_q <= index_s[2];
            if (lp_s[1] == lp_s[2])
                lp_q <= lp_s[2];
            if (lm_s[1] == lm_s[2])
                lm_q <= lm_s[2];
        end
    end

    assign home_act = home_q ~^ home_active_high;
    assign index_act = index_q ~^ index_active_high;
    // Limit on the side toward which the axis currently moves
    assign limit_fwd = (drive_dir == `DIR_PLUS ? lp_q : lm_q)
        ~^ limit_active_high;
    // Detector is the search-side limit when limit is selected
    assign detect = (sensor_sel == `SENSOR_LIMIT) ?
        ((dir_step12 == `DIR_PLUS ? lp_q : lm_q) ~^ limit_active_high) :
        home_act;

    pulse_rate_gen #(.CLK_HZ(CLK_HZ)) u_rate (
        .mclk(mclk),
        .srst(srst),
        .run(run),
        .ramp(ramp),
        .halt(halt),
        .start_pps(start_pps),
        .drive_pps(ramp ? drive_pps : cur_pps),
        .accel_ms(accel_ms),
        .step(step),
        .stopped(stopped)
    );

    always @(posedge mclk) begin
        if (srst) begin
            state <= S_IDLE;
            step_no <= 3'h0;
            after_stop <= 3'h0;
            remain <= {OFS_W{1'b0}};
            run <= 1'b0;
            ramp <= 1'b0;
            halt <= 1'b0;
            cur_pps <= {`SPD_W{1'b0}};
            drive_pulse <= 1'b0;
            drive_dir <= `DIR_MINUS;
            busy <= 1'b0;
            done <= 1'b0;
            search_error <= 1'b0;
            error_code <= `ERR_NONE;
            soft_limit_inhibit <= 1'b0;
            position_clear <= 1'b0;
        end else begin
            drive_pulse <= run && step && !stopped;
            position_clear <= 1'b0;
            done <= 1'b0;
            case (state)
                S_IDLE: begin
                    run <= 1'b0;
                    halt <= 1'b0;
                    if (start) begin
                        busy <= 1'b1;
                        soft_limit_inhibit <= 1'b1;
                        search_error <= 1'b0;
                        error_code <= `ERR_NONE;
                        step_no <= 3'h0;
                        state <= S_NEXT;
                    end
                end
                S_NEXT: begin
                    // Skip disabled steps
                    if (step_no == 3'h4) begin
                        state <= S_END;
                    end else if (!step_enable[step_no[1:0]]) begin
                        step_no <= step_no + 3'h1;
                    end else begin
                        halt <= 1'b0;
                        run <= 1'b1;
                        case (step_no)
                            3'h0: begin
                                ramp <= trapezoid_with_start_speed;
                                cur_pps <= drive_pps;
                                drive_dir <= dir_step12;
                                state <= S_S1;
                            end
                            3'h1: begin
                                ramp <= 1'b0;
                                cur_pps <= slow_pps;
                                if (detect) begin
                                    drive_dir <= ~dir_step12;
                                    state <= S_S2_ESC;
                                end else begin
                                    drive_dir <= dir_step12;
                                    state <= S_S2_SRCH;
                                end
                            end
                            3'h2: begin
                                ramp <= 1'b0;
                                cur_pps <= slow_pps;
                                drive_dir <= dir_step3;
                                // Index active at entry: error
                                if (index_act) begin
                                    run <= 1'b0;
                                    error_code <= `ERR_SEARCH;
                                    state <= S_END;
                                end else begin
                                    state <= S_S3;
                                end
                            end
                            default: begin
                                ramp <= trapezoid_with_start_speed;
                                cur_pps <= drive_pps;
                                // Sign picks direction, magnitude is the count
                                drive_dir <= offset[OFS_W-1] ?
                                    `DIR_MINUS : `DIR_PLUS;
                                remain <= offset[OFS_W-1] ?
                                    (~offset + 1'b1) : offset;
                                state <= S_S4;
                            end
                        endcase
                    end
                end
                S_S1: begin
                    if (detect) begin
                        halt <= 1'b1;
                        after_stop <= 3'h1;
                        state <= S_STOP;
                    end else if (sensor_sel == `SENSOR_HOME && limit_fwd) begin
                        run <= 1'b0;
                        error_code <= `ERR_LIMIT;
                        state <= S_END;
                    end
                end
                S_S2_ESC: begin
                    if (!detect) begin
                        drive_dir <= dir_step12;
                        state <= S_S2_SRCH;
                    end
                end
                S_S2_SRCH: begin
                    if (detect) begin
                        run <= 1'b0;
                        step_no <= 3'h2;
                        state <= S_NEXT;
                    end else if (sensor_sel == `SENSOR_HOME && limit_fwd) begin
                        run <= 1'b0;
                        error_code <= `ERR_LIMIT;
                        state <= S_END;
                    end
                end
                S_S3: begin
                    if (limit_fwd) begin
                        run <= 1'b0;
                        error_code <= `ERR_LIMIT;
                        state <= S_END;
                    end else if (index_act) begin
                        run <= 1'b0;
                        step_no <= 3'h3;
                        state <= S_NEXT;
                    end
                end
                S_S4: begin
                    if (remain == {OFS_W{1'b0}}) begin
                        run <= 1'b0;
                        step_no <= 3'h4;
                        state <= S_NEXT;
                    end else if (drive_pulse) begin
                        remain <= remain - 1'b1;
                    end
                end
                S_STOP: begin
                    // Stop, decelerating only when ramp is set, finishes once the generator idles
                    if (stopped) begin
                        run <= 1'b0;
                        step_no <= after_stop;
                        state <= S_NEXT;
                    end
                end
                S_END: begin
                    busy <= 1'b0;
                    soft_limit_inhibit <= 1'b0;
                    run <= 1'b0;
                    done <= 1'b1;
                    if (error_code != `ERR_NONE)
                        search_error <= 1'b1;
                    else if (position_clear_en)
                        position_clear <= 1'b1;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // home_search_sequencer

// ---- core/home_search_map.vh ----
`ifndef HOME_SEARCH_MAP_VH
`define HOME_SEARCH_MAP_VH
// Clock rate in Hz
`define CLK_HZ 25000000
// Speed in pulses per second, time in milliseconds
`define DEF_START_PPS 4000
`define DEF_DRIVE_PPS 40000
`define DEF_SLOW_PPS 4000
`define DEF_ACCEL_MS 500
`define DEF_OFFSET 100
// Width of speed and offset fields
`define SPD_W 19
`define OFS_W 32
// Sensor select codes
`define SENSOR_HOME 1'b0
`define SENSOR_LIMIT 1'b1
// Direction codes
`define DIR_PLUS 1'b1
`define DIR_MINUS 1'b0
// Status error codes
`define ERR_NONE 2'h0
`define ERR_SEARCH 2'h1
`define ERR_LIMIT 2'h2
`endif

// ---- core/pulse_rate_gen.v ----
`timescale 1ns/1ps
`include "home_search_map.vh"
// Ramping step-rate generator: one-cycle step enable at the current speed.
module pulse_rate_gen #(
    parameter CLK_HZ = `CLK_HZ
) (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Control
    input wire run,
    input wire ramp,
    input wire halt,
    input wire [`SPD_W-1:0] start_pps,
    input wire [`SPD_W-1:0] drive_pps,
    input wire [13:0] accel_ms,
    // Outputs
    output reg step,
    output reg stopped
);
    reg [31:0] phase;
    reg [31:0] ramp_acc;
    reg [`SPD_W-1:0] speed;
    wire [31:0] span;
    wire [31:0] per_ms;
    wire [31:0] next_phase;
    wire [`SPD_W-1:0] rate;
    assign span = {13'h0000, drive_pps} - {13'h0000, start_pps};
    // Constant-speed moves follow the speed input at once, no stale speed
    assign rate = ramp ? speed : drive_pps;
    // Speed step every ms-fraction: rise of span over accel_ms milliseconds
    assign per_ms = CLK_HZ / 1000;
    assign next_phase = phase + {13'h0000, rate};
    always @(posedge mclk) begin
        if (srst) begin
            phase <= 32'h00000000;
            ramp_acc <= 32'h00000000;
            speed <= {`SPD_W{1'b0}};
            step <= 1'b0;
            stopped <= 1'b1;
        end else if (!run) begin
            phase <= 32'h00000000;
            ramp_acc <= 32'h00000000;
            speed <= start_pps;
            step <= 1'b0;
            stopped <= 1'b1;
        end else begin
            stopped <= 1'b0;
            if (next_phase >= CLK_HZ) begin
                phase <= next_phase - CLK_HZ;
                step <= 1'b1;
            end else begin
                phase <= next_phase;
                step <= 1'b0;
            end
            // Change speed by one pps each time the accumulator wraps;
            // trades ramp smoothness for a single adder
            if (ramp) begin
                if (ramp_acc + span >= per_ms * {18'h00000, accel_ms}) begin
                    ramp_acc <= ramp_acc + span - per_ms * {18'h00000, accel_ms};
                    if (halt && speed > start_pps)
                        speed <= speed - 1'b1;
                    else if (!halt && speed < drive_pps)
                        speed <= speed + 1'b1;
                end else begin
                    ramp_acc <= ramp_acc + span;
                end
                if (halt && speed <= start_pps)
                    stopped <= 1'b1;
            end else if (halt) begin
                stopped <= 1'b1;
            end
        end
    end
endmodule // pulse_rate_gen

// ---- testbench/home_search_checker.sv ----
`timescale 1ns/1ps
`include "home_search_map.vh"
module home_search_checker #(
    parameter OFS_W = 32
) (
    // Clock and reset
    input wire mclk,
    input wire srst,
    // Command and configuration
    input wire start,
    input wire [3:0] step_enable,
    input wire position_clear_en,
    input wire signed [OFS_W-1:0] offset,
    // Outputs watched
    input wire drive_pulse,
    input wire drive_dir,
    input wire busy,
    input wire done,
    input wire search_error,
    input wire [1:0] error_code,
    input wire soft_limit_inhibit,
    input wire position_clear
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    start_taken_a: assert property (!busy && start |=> busy)
        else $error("busy missing after start");
    inhibit_busy_a: assert property (busy |-> soft_limit_inhibit)
        else $error("soft limits not inhibited");
    done_pulse_a: assert property (done |=> !done)
        else $error("done longer than one cycle");
    done_ends_a: assert property (done |-> !busy)
        else $error("busy after done");
    clear_gate_a: assert property (position_clear |->
        position_clear_en && !search_error && done)
        else $error("position clear out of place");
    pulse_busy_a: assert property (drive_pulse |-> busy)
        else $error("pulse while idle");
    pulse_single_a: assert property (drive_pulse |=> !drive_pulse)
        else $error("pulse wider than one cycle");
    offset_dir_a: assert property (busy && step_enable == 4'h8 &&
        drive_pulse |-> drive_dir == !offset[OFS_W-1])
        else $error("offset direction wrong");
    error_code_a: assert property (search_error |->
        error_code != `ERR_NONE)
        else $error("error flag without code");
    cover property (done && !search_error);
    cover property (search_error);
    cover property (position_clear);
endmodule // home_search_checker

// ---- testbench/axis_model.sv ----
`timescale 1ns/1ps
module axis_model (
    // Clock and motion
    input wire mclk,
    input wire set_zero,
    input wire drive_pulse,
    input wire drive_dir,
    // Sensor zones and levels
    input wire signed [31:0] home_lo,
    input wire signed [31:0] home_hi,
    input wire signed [31:0] lim_minus,
    input wire signed [31:0] lim_plus,
    input wire signed [31:0] index_pos,
    input wire home_active_high,
    input wire limit_active_high,
    input wire index_active_high,
    // Pins and mechanical position
    output wire home_pin,
    output wire limit_minus_pin,
    output wire limit_plus_pin,
    output wire encoder_index_input,
    output reg signed [31:0] pos
);
    initial pos = 0;
    always @(posedge mclk) begin
        if (set_zero)
            pos <= 0;
        else if (drive_pulse === 1'b1)
            pos <= drive_dir ? pos + 1 : pos - 1;
    end
    // Active level when inside a zone, its inverse outside
    assign home_pin = (pos >= home_lo && pos <= home_hi) ~^ home_active_high;
    assign limit_minus_pin = (pos <= lim_minus) ~^ limit_active_high;
    assign limit_plus_pin = (pos >= lim_plus) ~^ limit_active_high;
    assign encoder_index_input = (pos == index_pos) ~^ index_active_high;
endmodule // axis_model

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`include "home_search_map.vh"
module testbench;
    reg mclk = 0, srst = 1, start = 0, set_zero = 0, sensor_sel = 0;
    reg home_active_high = 0, index_active_high = 0, limit_active_high = 1;
    reg [3:0] step_enable = 4'h0;
    reg dir_step12 = 0, dir_step3 = 1, position_clear_en = 1;
    reg trapezoid_with_start_speed = 1;
    reg [18:0] start_pps = 19'h3D090, drive_pps = 19'h7A120;
    reg [18:0] slow_pps = 19'h186A0;
    reg [13:0] accel_ms = 14'h0001;
    reg signed [31:0] offset = 32'h5, home_lo = 0, home_hi = 0;
    reg signed [31:0] lim_minus = -32'sh100, lim_plus = 32'sh100;
    reg signed [31:0] index_pos = 32'sh100;
    wire home_pin, encoder_index_input, limit_plus_pin, limit_minus_pin;
    wire drive_pulse, drive_dir, busy, done, search_error;
    wire soft_limit_inhibit, position_clear;
    wire [1:0] error_code;
    wire signed [31:0] pos;
    integer n_mismatch = 0, cmp_count = 0, k, min_pos, max_pos;
    reg [31:0] seed = 32'ha7c4;
    reg clr_seen, err_seen;
    reg [1:0] code_seen;
    always #20 mclk = ~mclk;
    home_search_sequencer u_dut (.mclk, .srst, .start, .sensor_sel,
        .home_active_high, .index_active_high, .limit_active_high,
        .step_enable, .dir_step12, .dir_step3, .position_clear_en,
        .trapezoid_with_start_speed, .start_pps, .drive_pps, .accel_ms,
        .slow_pps, .offset, .home_pin, .encoder_index_input,
        .limit_plus_pin, .limit_minus_pin, .drive_pulse, .drive_dir,
        .busy, .done, .search_error, .error_code, .soft_limit_inhibit,
        .position_clear);
    axis_model u_axis (.mclk, .set_zero, .drive_pulse, .drive_dir,
        .home_lo, .home_hi, .lim_minus, .lim_plus, .index_pos,
        .home_active_high, .limit_active_high, .index_active_high,
        .home_pin, .limit_minus_pin, .limit_plus_pin,
        .encoder_index_input, .pos);
    always @(negedge mclk) begin
        if (pos < min_pos) min_pos = pos;
        if (pos > max_pos) max_pos = pos;
    end
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task print_verdict;
        begin
            $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
            if (n_mismatch == 0 && cmp_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp, input [95:0] what);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("Error %0s expected %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    // Zero the axis, let the pin synchronisers settle, then one search
    task run;
        integer i;
        reg got;
        begin
            set_zero = 1;
            @(negedge mclk);
            set_zero = 0;
            repeat (10) @(negedge mclk);
            min_pos = 0;
            max_pos = 0;
            clr_seen = 0;
            got = 0;
            start = 1;
            @(negedge mclk);
            start = 0;
            for (i = 0; i < 30000 && !got; i = i + 1) begin
                @(negedge mclk);
                if (position_clear === 1'b1) clr_seen = 1;
                if (done === 1'b1) got = 1;
            end
            if (!got) begin
                n_mismatch = n_mismatch + 1;
                print_verdict;
            end
            err_seen = search_error;
            code_seen = error_code;
        end
    endtask
    initial begin
        repeat (10) @(negedge mclk);
        srst = 0;
        // Offset move alone, random size, sign alternating plus then minus
        step_enable = 4'h8;
        for (k = 0; k < 4; k = k + 1) begin
            seed = lfsr(seed);
            offset = {29'h0, seed[2:0]} + 32'h1;
            if (k[0]) offset = -offset;
            position_clear_en = k[1];
            trapezoid_with_start_speed = k[0];
            run;
            check(pos, offset, "offset_pos");
            check(clr_seen, position_clear_en, "pos_clear");
            check(err_seen, 1'b0, "offset_err");
        end
        // Fast then slow search on the home zone, limit beyond it
        // Zone wide enough to hold the decelerating overshoot
        home_lo = -32'sd100;
        home_hi = -32'sd20;
        lim_minus = -32'sd200;
        step_enable = 4'h3;
        run;
        check(min_pos <= home_hi, 1'b1, "home_reach");
        check(home_pin, 1'b0, "home_rest");
        check(err_seen, 1'b0, "home_err");
        // Step 2 alone starting inside the active zone
        home_lo = -32'sd5;
        home_hi = 32'sd5;
        home_active_high = 1;
        step_enable = 4'h2;
        run;
        check(max_pos > home_hi, 1'b1, "escape");
        check(home_pin, 1'b1, "re_detect");
        // Minus limit as detector, offset leaves it
        sensor_sel = `SENSOR_LIMIT;
        trapezoid_with_start_speed = 1;
        home_lo = 32'sd1000;
        home_hi = 32'sd1000;
        lim_minus = -32'sd15;
        limit_active_high = 0;
        offset = 32'sd5;
        step_enable = 4'hB;
        run;
        check(min_pos <= lim_minus, 1'b1, "limit_reach");
        check(min_pos < lim_minus - 3, 1'b1, "decel_stop");
        check(pos > lim_minus, 1'b1, "limit_leave");
        check(err_seen, 1'b0, "limit_err");
        // Index search at slow speed, stops on the index
        sensor_sel = `SENSOR_HOME;
        lim_minus = -32'sh100;
        limit_active_high = 1;
        dir_step3 = `DIR_PLUS;
        index_active_high = 1;
        index_pos = 32'sd7;
        step_enable = 4'h4;
        run;
        check(pos, 32'sd7, "index_stop");
        check(clr_seen, 1'b1, "index_clear");
        // Index already active at entry aborts with an error
        index_active_high = 0;
        index_pos = 0;
        run;
        check(err_seen, 1'b1, "index_err");
        check(code_seen, `ERR_SEARCH, "err_code");
        check(clr_seen, 1'b0, "err_clear");
        // Home never found: the overrun limit aborts step 1
        step_enable = 4'h1;
        lim_minus = -32'sd10;
        run;
        check(err_seen, 1'b1, "limit_abort");
        check(code_seen, `ERR_LIMIT, "limit_code");
        check(pos <= lim_minus, 1'b1, "limit_hit");
        print_verdict;
    end
endmodule // testbench
bind home_search_sequencer home_search_checker #(.OFS_W(OFS_W)) u_chk (
    .mclk, .srst, .start, .step_enable, .position_clear_en, .offset,
    .drive_pulse, .drive_dir, .busy, .done, .search_error, .error_code,
    .soft_limit_inhibit, .position_clear);
